//--- shared/acb_pkg.sv
`default_nettype none
package acb_pkg;
    // register offsets within a page
    localparam logic [6:0] ACB_OFF_PAGE = 7'h00;
    localparam logic [6:0] ACB_OFF_CFG = 7'h01;
    localparam logic [6:0] ACB_OFF_COEF = 7'h08;
    // slot index of the first coefficient word (offset 8 / 4)
    localparam logic [4:0] ACB_SLOT_BASE = 5'h02;
    // page numbers
    localparam logic [7:0] ACB_PG_A_FIRST = 8'h08;
    localparam logic [7:0] ACB_PG_A_LAST = 8'h10;
    localparam logic [7:0] ACB_PG_B_FIRST = 8'h1A;
    localparam logic [7:0] ACB_PG_B_LAST = 8'h22;
    localparam logic [7:0] ACB_PG_DAC_CFG = 8'h2C;
    // coefficient geometry
    localparam logic [8:0] ACB_COEF_PER_PAGE = 9'h01E;
    localparam logic [8:0] ACB_NUM_COEF = 9'h100;
    localparam logic [1:0] ACB_LANE_MSB = 2'h0;
    localparam logic [1:0] ACB_LANE_MID = 2'h1;
    localparam logic [1:0] ACB_LANE_LSB = 2'h2;
    // configuration register bit positions
    localparam int ACB_BIT_EN = 2;
    localparam int ACB_BIT_FLAG = 1;
    localparam int ACB_BIT_SWAP = 0;
    // reset values
    localparam logic [7:0] ACB_PAGE_RST = 8'h00;
    localparam logic [7:0] ACB_BYTE_ZERO = 8'h00;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acb_req_s;

    typedef struct packed {
        logic en;
        logic flag;
        logic pend;
    } acb_adapt_s;

    localparam acb_adapt_s ACB_ADAPT_RST = '{en: 1'b0, flag: 1'b0, pend: 1'b0};

    typedef struct packed {
        logic [7:0] page;
        acb_adapt_s adc;
        acb_adapt_s dac;
        logic [15:0] stage;
        logic [7:0] rdata;
        logic [23:0] coef;
    } acb_state_s;
endpackage
`default_nettype wire

//--- logic/acb_coef_bank.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module acb_coef_bank
    import acb_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // register port
    input wire acb_req_s reg_req_in,
    output logic [7:0] reg_rdata_out,
    // adc datapath
    input wire logic adc_pwr_dn_in,
    input wire logic adc_frame_in,
    input wire logic [7:0] adc_coef_idx_in,
    output logic [23:0] adc_coef_out,
    output logic adc_adapt_en_out,
    output logic adc_bank_flag_out,
    // dac datapath
    input wire logic dac_frame_in,
    output logic dac_adapt_en_out,
    output logic dac_bank_flag_out
);
    acb_state_s st_reg;
    acb_state_s st_next;

    // coefficient storage has no reset; contents undefined after power-up
    logic [23:0] mem_a [256];
    logic [23:0] mem_b [256];

    logic in_a;
    logic in_b;
    logic [7:0] rel_page;
    logic [4:0] slot;
    logic [8:0] idx;
    logic [1:0] lane;
    logic access_ok;
    logic coef_hit;
    logic phys_b;
    logic commit_a;
    logic commit_b;
    logic [23:0] commit_word;
    logic [23:0] host_word;
    logic adc_swap;
    logic dac_swap;
    logic cfg_wr;

    always_comb begin
        in_a = (st_reg.page >= ACB_PG_A_FIRST) && (st_reg.page <= ACB_PG_A_LAST);
        in_b = (st_reg.page >= ACB_PG_B_FIRST) && (st_reg.page <= ACB_PG_B_LAST);
        rel_page = in_b ? (st_reg.page - ACB_PG_B_FIRST) : (st_reg.page - ACB_PG_A_FIRST);
        slot = 5'(reg_req_in.addr[6:2] - ACB_SLOT_BASE);
        // page 8 starts at C0, pages 9-16 continue at C30
        idx = 9'(rel_page[3:0] * ACB_COEF_PER_PAGE) + 9'(slot);
        lane = reg_req_in.addr[1:0];
        access_ok = st_reg.adc.en || adc_pwr_dn_in;
        coef_hit = (in_a || in_b) && (reg_req_in.addr >= ACB_OFF_COEF)
            && (idx < ACB_NUM_COEF) && access_ok;
        // when adaptive with flag set, the page ranges swap: A pages reach mem_b, B pages reach mem_a
        phys_b = in_b ^ (st_reg.adc.en && st_reg.adc.flag);
        host_word = phys_b ? mem_b[idx[7:0]] : mem_a[idx[7:0]];
        commit_word = {st_reg.stage, reg_req_in.wdata};
        // only the lsb write touches the array, so no half-written word
        commit_a = reg_req_in.wr && coef_hit && (lane == ACB_LANE_LSB) && !phys_b;
        commit_b = reg_req_in.wr && coef_hit && (lane == ACB_LANE_LSB) && phys_b;
        adc_swap = adc_frame_in && st_reg.adc.en && st_reg.adc.pend;
        dac_swap = dac_frame_in && st_reg.dac.en && st_reg.dac.pend;
        cfg_wr = reg_req_in.wr && (reg_req_in.addr == ACB_OFF_CFG);
    end

    always_comb begin
        st_next = st_reg;
        st_next.rdata = ACB_BYTE_ZERO;

        // swaps only in adaptive mode; a pending request waits otherwise
        if (adc_swap) begin
            st_next.adc.flag = !st_reg.adc.flag;
            st_next.adc.pend = 1'b0;
        end
        if (dac_swap) begin
            st_next.dac.flag = !st_reg.dac.flag;
            st_next.dac.pend = 1'b0;
        end

        if (reg_req_in.wr) begin
            if (reg_req_in.addr == ACB_OFF_PAGE) begin
                st_next.page = reg_req_in.wdata;
            end else if (cfg_wr && st_reg.page == ACB_PG_A_FIRST) begin
                st_next.adc.en = reg_req_in.wdata[ACB_BIT_EN];
                // a new request in the swap cycle survives
                if (reg_req_in.wdata[ACB_BIT_SWAP]) begin
                    st_next.adc.pend = 1'b1;
                end
            end else if (cfg_wr && st_reg.page == ACB_PG_DAC_CFG) begin
                st_next.dac.en = reg_req_in.wdata[ACB_BIT_EN];
                if (reg_req_in.wdata[ACB_BIT_SWAP]) begin
                    st_next.dac.pend = 1'b1;
                end
            end else if (coef_hit && lane == ACB_LANE_MSB) begin
                st_next.stage[15:8] = reg_req_in.wdata;
            end else if (coef_hit && lane == ACB_LANE_MID) begin
                st_next.stage[7:0] = reg_req_in.wdata;
            end
        end

        if (reg_req_in.rd) begin
            if (reg_req_in.addr == ACB_OFF_PAGE) begin
                st_next.rdata = st_reg.page;
            end else if (reg_req_in.addr == ACB_OFF_CFG && st_reg.page == ACB_PG_A_FIRST) begin
                // reserved upper bits stay zero
                st_next.rdata[ACB_BIT_EN] = st_reg.adc.en;
                st_next.rdata[ACB_BIT_FLAG] = st_reg.adc.flag;
                st_next.rdata[ACB_BIT_SWAP] = st_reg.adc.pend;
            end else if (reg_req_in.addr == ACB_OFF_CFG && st_reg.page == ACB_PG_DAC_CFG) begin
                st_next.rdata[ACB_BIT_EN] = st_reg.dac.en;
                st_next.rdata[ACB_BIT_FLAG] = st_reg.dac.flag;
                st_next.rdata[ACB_BIT_SWAP] = st_reg.dac.pend;
            end else if (coef_hit) begin
                case (lane)
                    ACB_LANE_MSB: st_next.rdata = host_word[23:16];
                    ACB_LANE_MID: st_next.rdata = host_word[15:8];
                    ACB_LANE_LSB: st_next.rdata = host_word[7:0];
                    default: st_next.rdata = ACB_BYTE_ZERO;
                endcase
            end
            // offsets 2-7 and unmapped locations fall through as zero
        end

        // filter side: bank A unless adaptive with flag set
        if (st_reg.adc.en && st_reg.adc.flag) begin
            st_next.coef = mem_b[adc_coef_idx_in];
        end else begin
            st_next.coef = mem_a[adc_coef_idx_in];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg.page <= ACB_PAGE_RST;
            st_reg.adc <= ACB_ADAPT_RST;
            st_reg.dac <= ACB_ADAPT_RST;
            st_reg.stage <= 16'h0000;
            st_reg.rdata <= ACB_BYTE_ZERO;
            st_reg.coef <= 24'h000000;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (commit_a) begin
            mem_a[idx[7:0]] <= commit_word;
        end
        if (commit_b) begin
            mem_b[idx[7:0]] <= commit_word;
        end
    end

    assign reg_rdata_out = st_reg.rdata;
    assign adc_coef_out = st_reg.coef;
    assign adc_adapt_en_out = st_reg.adc.en;
    assign adc_bank_flag_out = st_reg.adc.flag;
    assign dac_adapt_en_out = st_reg.dac.en;
    assign dac_bank_flag_out = st_reg.dac.flag;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    property p_page_write;
        reg_req_in.wr && reg_req_in.addr == ACB_OFF_PAGE
            |=> st_reg.page == $past(reg_req_in.wdata);
    endproperty
    a_page_write: assert property (p_page_write)
        else $error("page select not taken");

    property p_page_read;
        reg_req_in.rd && reg_req_in.addr == ACB_OFF_PAGE
            |=> reg_rdata_out == $past(st_reg.page);
    endproperty
    a_page_read: assert property (p_page_read)
        else $error("page select read wrong");

    property p_reserved_zero;
        reg_req_in.rd && reg_req_in.addr > ACB_OFF_CFG && reg_req_in.addr < ACB_OFF_COEF
            |=> reg_rdata_out == ACB_BYTE_ZERO;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved offset read nonzero");

    property p_cfg_upper_zero;
        reg_req_in.rd && reg_req_in.addr == ACB_OFF_CFG |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_cfg_upper_zero: assert property (p_cfg_upper_zero)
        else $error("reserved config bits nonzero");

    property p_blocked_access;
        !st_reg.adc.en && !adc_pwr_dn_in |-> !commit_a && !commit_b;
    endproperty
    a_blocked_access: assert property (p_blocked_access)
        else $error("coefficient written while channel active");

    property p_dac_en;
        reg_req_in.wr && reg_req_in.addr == ACB_OFF_CFG && st_reg.page == ACB_PG_DAC_CFG
            |=> dac_adapt_en_out == $past(reg_req_in.wdata[ACB_BIT_EN]);
    endproperty
    a_dac_en: assert property (p_dac_en)
        else $error("dac adaptive enable not written");

    property p_dac_flag_cause;
        $changed(dac_bank_flag_out) |-> $past(dac_frame_in && st_reg.dac.en && st_reg.dac.pend);
    endproperty
    a_dac_flag_cause: assert property (p_dac_flag_cause)
        else $error("dac flag moved without swap");

    property p_adc_swap;
        adc_frame_in && st_reg.adc.en && st_reg.adc.pend && !cfg_wr
            |=> $changed(adc_bank_flag_out) && !st_reg.adc.pend;
    endproperty
    a_adc_swap: assert property (p_adc_swap)
        else $error("adc swap missed or request not cleared");

    property p_adc_flag_cause;
        $changed(adc_bank_flag_out) |-> $past(adc_swap);
    endproperty
    a_adc_flag_cause: assert property (p_adc_flag_cause)
        else $error("adc flag moved without swap");

    property p_commit_lsb_only;
        commit_a || commit_b |-> reg_req_in.addr[1:0] == ACB_LANE_LSB && idx < ACB_NUM_COEF;
    endproperty
    a_commit_lsb_only: assert property (p_commit_lsb_only)
        else $error("coefficient committed from a non-final byte");

    property p_coef_range;
        commit_a && st_reg.page == ACB_PG_A_FIRST |-> idx < ACB_COEF_PER_PAGE;
    endproperty
    a_coef_range: assert property (p_coef_range)
        else $error("page 8 index out of range");

    property p_bank_b_page;
        commit_b && !st_reg.adc.en |-> in_b;
    endproperty
    a_bank_b_page: assert property (p_bank_b_page)
        else $error("bank b written from wrong page");

    property p_bank_a_page;
        commit_a && !st_reg.adc.en |-> in_a;
    endproperty
    a_bank_a_page: assert property (p_bank_a_page)
        else $error("bank a written from wrong page");

    property p_rdata_idle;
        !reg_req_in.rd |=> reg_rdata_out == ACB_BYTE_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");

    property p_page_hold;
        !(reg_req_in.wr && reg_req_in.addr == ACB_OFF_PAGE) |=> $stable(st_reg.page);
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("page select moved without a write");

    property p_adc_en;
        cfg_wr && st_reg.page == ACB_PG_A_FIRST
            |=> adc_adapt_en_out == $past(reg_req_in.wdata[ACB_BIT_EN]);
    endproperty
    a_adc_en: assert property (p_adc_en)
        else $error("adc adaptive enable not written");

    property p_adc_pend_set;
        cfg_wr && st_reg.page == ACB_PG_A_FIRST && reg_req_in.wdata[ACB_BIT_SWAP]
            |=> st_reg.adc.pend;
    endproperty
    a_adc_pend_set: assert property (p_adc_pend_set)
        else $error("adc swap request lost");

    property p_dac_pend_set;
        cfg_wr && st_reg.page == ACB_PG_DAC_CFG && reg_req_in.wdata[ACB_BIT_SWAP]
            |=> st_reg.dac.pend;
    endproperty
    a_dac_pend_set: assert property (p_dac_pend_set)
        else $error("dac swap request lost");

    property p_dac_swap;
        dac_swap && !cfg_wr |=> $changed(dac_bank_flag_out) && !st_reg.dac.pend;
    endproperty
    a_dac_swap: assert property (p_dac_swap)
        else $error("dac swap missed or request not cleared");

    property p_adc_flag_idle;
        !st_reg.adc.en |=> $stable(adc_bank_flag_out);
    endproperty
    a_adc_flag_idle: assert property (p_adc_flag_idle)
        else $error("adc flag moved outside adaptive mode");

    property p_dac_flag_idle;
        !st_reg.dac.en |=> $stable(dac_bank_flag_out);
    endproperty
    a_dac_flag_idle: assert property (p_dac_flag_idle)
        else $error("dac flag moved outside adaptive mode");

    property p_dac_flag_ro;
        cfg_wr && st_reg.page == ACB_PG_DAC_CFG && !dac_swap
            |=> $stable(dac_bank_flag_out);
    endproperty
    a_dac_flag_ro: assert property (p_dac_flag_ro)
        else $error("dac flag taken from a host write");

    property p_stage_msb;
        reg_req_in.wr && coef_hit && lane == ACB_LANE_MSB
            |=> st_reg.stage[15:8] == $past(reg_req_in.wdata);
    endproperty
    a_stage_msb: assert property (p_stage_msb)
        else $error("msb byte not staged");

    property p_stage_mid;
        reg_req_in.wr && coef_hit && lane == ACB_LANE_MID
            |=> st_reg.stage[7:0] == $past(reg_req_in.wdata);
    endproperty
    a_stage_mid: assert property (p_stage_mid)
        else $error("middle byte not staged");

    property p_pad_read;
        reg_req_in.rd && coef_hit && (&reg_req_in.addr[1:0])
            |=> reg_rdata_out == ACB_BYTE_ZERO;
    endproperty
    a_pad_read: assert property (p_pad_read)
        else $error("pad byte of a coefficient slot read nonzero");

    property p_blocked_read;
        reg_req_in.rd && (in_a || in_b) && reg_req_in.addr >= ACB_OFF_COEF && !access_ok
            |=> reg_rdata_out == ACB_BYTE_ZERO;
    endproperty
    a_blocked_read: assert property (p_blocked_read)
        else $error("coefficient read while channel active");

    c_adc_swap: cover property (adc_swap);
    c_dac_swap: cover property (dac_swap);
    c_commit_b: cover property (commit_b ##1 reg_req_in.rd);
    c_blocked: cover property (reg_req_in.wr && (in_a || in_b) && !access_ok);
    c_pend_wait: cover property (dac_frame_in && !st_reg.dac.en && st_reg.dac.pend);
endmodule // acb_coef_bank
`default_nettype wire

//--- verif/test_acb_coef_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_acb_coef_bank
    import acb_pkg::*;
;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    acb_req_s req = '0;
    logic [7:0] rdata;
    logic pwr_dn = 1'b1;
    logic afr = 1'b0;
    logic dfr = 1'b0;
    logic [7:0] idx = 8'h00;
    logic [23:0] coef;
    logic aen, aflg, den, dflg;
    int miscompares = 0;
    int compares = 0;

    acb_coef_bank dut_u (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
        .reg_rdata_out(rdata), .adc_pwr_dn_in(pwr_dn), .adc_frame_in(afr),
        .adc_coef_idx_in(idx), .adc_coef_out(coef), .adc_adapt_en_out(aen),
        .adc_bank_flag_out(aflg), .dac_frame_in(dfr), .dac_adapt_en_out(den),
        .dac_bank_flag_out(dflg));

    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_coef(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: coef %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        req <= '0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        req <= '0;
        #1 chk_byte(rdata, exp);
    endtask

    task automatic wcoef(input logic [7:0] pg, input logic [6:0] off, input logic [23:0] v);
        wr(ACB_OFF_PAGE, pg);
        wr(off, v[23:16]);
        wr(off + 7'h01, v[15:8]);
        wr(off + 7'h02, v[7:0]);
    endtask

    task automatic fchk(input logic [7:0] i, input logic [23:0] exp);
        @(posedge sys_clk_in);
        idx <= i;
        @(posedge sys_clk_in);
        #1 chk_coef(coef, exp);
    endtask

    task automatic frame(input logic dac);
        @(posedge sys_clk_in);
        dfr <= dac;
        afr <= ~dac;
        @(posedge sys_clk_in);
        dfr <= 1'b0;
        afr <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
    endtask

    task automatic t_reset_page();
        logic [7:0] vals [3] = '{8'hFF, 8'h5A, 8'h00};
        rd_chk(ACB_OFF_PAGE, 8'h00);
        foreach (vals[i]) begin
            wr(ACB_OFF_PAGE, vals[i]);
            rd_chk(ACB_OFF_PAGE, vals[i]);
        end
        wr(ACB_OFF_PAGE, ACB_PG_DAC_CFG);
        rd_chk(ACB_OFF_CFG, 8'h00);
        chk_bit(den, 1'b0);
        chk_bit(dflg, 1'b0);
    endtask

    task automatic t_reserved();
        wr(ACB_OFF_PAGE, 8'h09);
        for (int a = 1; a < 8; a++) begin
            wr(7'(a), 8'h00);
            rd_chk(7'(a), 8'h00);
        end
    endtask

    // powered down, so non-adaptive access is allowed
    task automatic t_coef();
        wcoef(ACB_PG_A_FIRST, ACB_OFF_COEF, 24'h112233);
        wcoef(8'h09, ACB_OFF_COEF, 24'h445566);
        wcoef(ACB_PG_A_LAST, 7'h44, 24'h778899);
        wcoef(ACB_PG_B_FIRST, ACB_OFF_COEF, 24'hAABBCC);
        wcoef(ACB_PG_B_LAST, 7'h44, 24'hDDEEF0);
        rd_chk(7'h44, 8'hDD);
        rd_chk(7'h46, 8'hF0);
        wr(ACB_OFF_PAGE, 8'h09);
        rd_chk(7'h08, 8'h44);
        rd_chk(7'h09, 8'h55);
        fchk(8'h00, 24'h112233);
        fchk(8'h1E, 24'h445566);
        fchk(8'hFF, 24'h778899);
        // filter must not see a half-written word
        wr(7'h08, 8'h01);
        fchk(8'h1E, 24'h445566);
        wr(7'h09, 8'h02);
        wr(7'h0A, 8'h03);
        fchk(8'h1E, 24'h010203);
    endtask

    task automatic t_power();
        @(posedge sys_clk_in);
        pwr_dn <= 1'b0;
        wcoef(8'h09, ACB_OFF_COEF, 24'hFFFFFF);
        rd_chk(7'h08, 8'h00);
        @(posedge sys_clk_in);
        pwr_dn <= 1'b1;
        rd_chk(7'h08, 8'h01);
    endtask

    task automatic t_dac();
        wr(ACB_OFF_PAGE, ACB_PG_DAC_CFG);
        wr(ACB_OFF_CFG, 8'h01);
        frame(1'b1);
        rd_chk(ACB_OFF_CFG, 8'h01);
        chk_bit(dflg, 1'b0);
        wr(ACB_OFF_CFG, 8'hFF);
        rd_chk(ACB_OFF_CFG, 8'h05);
        chk_bit(den, 1'b1);
        frame(1'b1);
        rd_chk(ACB_OFF_CFG, 8'h06);
        chk_bit(dflg, 1'b1);
    endtask

    // channel active: adaptive mode alone opens the banks
    task automatic t_adc();
        @(posedge sys_clk_in);
        pwr_dn <= 1'b0;
        wr(ACB_OFF_PAGE, ACB_PG_A_FIRST);
        wr(ACB_OFF_CFG, 8'h05);
        frame(1'b0);
        rd_chk(ACB_OFF_CFG, 8'h06);
        chk_bit(aen, 1'b1);
        chk_bit(aflg, 1'b1);
        fchk(8'h00, 24'hAABBCC);
        wr(ACB_OFF_PAGE, ACB_PG_B_FIRST);
        rd_chk(7'h08, 8'h11);
    endtask

    initial begin
        repeat (4) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        t_reset_page();
        t_reserved();
        t_coef();
        t_power();
        t_dac();
        t_adc();
        stop_test();
    end

    // whole run is under two hundred cycles
    initial begin
        #(40 * 5000);
        miscompares++;
        stop_test();
    end
endmodule // test_acb_coef_bank
`default_nettype wire
